// ---- logic/dac_port_pkg.sv ----
package dac_port_pkg;

	// four-wire word layout, most significant bit first
	localparam int          WORD_BITS    = 24;
	localparam int          AB_POS       = 23;
	localparam int          RW_POS       = 22;
	localparam int          CHAN_LSB     = 16;
	localparam int          REGSEL_LSB   = 14;
	localparam int          DATA_BITS    = 14;
	localparam int          ECHO_BITS    = 10;
	localparam logic [4:0]  WORD_CNT_END = 5'h18;

	// two-wire slave addressing and pointer codes
	localparam logic [4:0]  SLAVE_PREFIX = 5'h15;
	localparam logic [7:0]  BURST_PTR    = 8'hFF;
	localparam logic [3:0]  BIT_ACK      = 4'h8;
	localparam logic [3:0]  BIT_LAST     = 4'h7;

	// data byte pair: select bits on top of the high byte
	localparam int          HI_REG_LSB   = 6;
	localparam int          HI_DATA_BITS = 6;

	// reset values
	localparam logic [5:0]  CHAN_RST     = 6'h00;
	localparam logic [23:0] WORD_RST     = 24'h000000;

	// one register update towards the register file
	typedef struct packed {
		logic        ab;
		logic [5:0]  chan;
		logic [1:0]  regsel;
		logic [13:0] data;
	} wr_cmd_s;

	// one readback selection
	typedef struct packed {
		logic [5:0] chan;
		logic [1:0] regsel;
	} rd_req_s;

	typedef enum logic [2:0] {
		PH_IDLE = 3'b000,
		PH_ADDR = 3'b001,
		PH_PTR  = 3'b010,
		PH_DHI  = 3'b011,
		PH_DLO  = 3'b100
	} phase_e;

endpackage

// ---- logic/dac_host_serial_port.sv ----
// Behaviour
// R1 - read/write bit one means read request
// R2 - channel and select pick register, rest ignored
// R3 - next frame shifts selected register out
// R4 - host sends all-zero word to fetch data
// R5 - low fourteen bits data, top ten echo
// R6 - output changes rising, valid on falling edges
// R7 - clock idling high: first bit at sync fall
// R8 - capture falling edges msb first, shift rising
// R9 - select pin low: two-wire slave, never clock
// R10 - address 10101 plus two strap pins
// R11 - start/stop while clock high; restart continues
// R12 - acknowledge every byte during ninth clock
// R13 - idle waits start and address, write only
// R14 - address, pointer, two data bytes update channel
// R15 - no stop: new pointer plus data repeats
// R16 - pointer 0xFF bursts from channel zero upward
// R17 - burst data select bits choose register
// R18 - stop ends any mode; burst writes bank A
// R19 - 24-bit word: ab, rw, chan, select, data
// R20 - sync high before 24 clocks drops word
// R21 - foreign address: no acknowledge, wait start
module dac_host_serial_port (
	input  wire logic                   sys_clk_i,         // 20 MHz core clock
	input  wire logic                   arst_n_i,          // async reset, low
	input  wire logic                   spi_mode_i,        // 1 four-wire, 0 two-wire
	input  wire logic                   spi_sclk_i,        // four-wire link clock
	input  wire logic                   frame_sync_n_i,    // frame sync, low
	input  wire logic                   spi_din_i,         // four-wire data in
	output logic                        serial_data_out_o, // readback data out
	input  wire logic                   scl_i,             // two-wire clock level
	input  wire logic                   sda_i,             // two-wire data level
	output logic                        sda_o,             // data drive value
	output logic                        sda_oe_n_o,        // low: pull data low
	input  wire logic                   address_strap_1_i, // slave address bit 1
	input  wire logic                   address_strap_0_i, // slave address bit 0
	output logic                        wr_valid_o,        // one-cycle write strobe
	output dac_port_pkg::wr_cmd_s       wr_cmd_o,          // write contents
	output logic                        rd_req_o,          // one-cycle read strobe
	output dac_port_pkg::rd_req_s       rd_sel_o,          // register to read
	input  wire logic [13:0]            rd_data_i          // read data, next cycle
);

	// ---------------- link clock domain ----------------

	logic        frame_clr;
	// bit count and incoming shift
	logic [4:0]  fcnt_q;
	logic [23:0] rx_shift_q;
	// complete word and its handoff toggle
	logic [23:0] rx_word_q;
	logic        rx_tgl_q;
	// readback output flops; the tx word lives on the core side
	logic        first_q;
	logic        started_q;
	logic        out_q;
	logic [23:0] tx_word_q;

	// sync high clears the frame; a short frame never completes
	assign frame_clr = frame_sync_n_i | ~arst_n_i; // R20

	// input bits on falling edges, msb first, then ignore clock
	always_ff @(negedge spi_sclk_i or posedge frame_clr) begin
		if (frame_clr) begin
			fcnt_q     <= 5'h00;
			rx_shift_q <= dac_port_pkg::WORD_RST;
		end else if (fcnt_q != dac_port_pkg::WORD_CNT_END) begin
			fcnt_q     <= fcnt_q + 5'h01; // R8
			rx_shift_q <= {rx_shift_q[22:0], spi_din_i}; // R8 R19
		end
	end

	// whole word handed over on the 24th falling edge only
	always_ff @(negedge spi_sclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rx_word_q <= dac_port_pkg::WORD_RST;
			rx_tgl_q  <= 1'b0;
		end else if (!frame_sync_n_i &&
			fcnt_q == dac_port_pkg::WORD_CNT_END - 5'h01) begin
			rx_word_q <= {rx_shift_q[22:0], spi_din_i}; // R20
			rx_tgl_q  <= ~rx_tgl_q;
		end
	end

	// msb ready at sync fall for a clock that idles high
	always_ff @(negedge frame_sync_n_i or negedge arst_n_i) begin
		if (!arst_n_i)
			first_q <= 1'b0;
		else
			first_q <= tx_word_q[dac_port_pkg::AB_POS]; // R7
	end

	// later bits change on rising edges, valid on falling ones
	always_ff @(posedge spi_sclk_i or posedge frame_clr) begin
		if (frame_clr) begin
			started_q <= 1'b0;
			out_q     <= 1'b0;
		end else if (fcnt_q != dac_port_pkg::WORD_CNT_END) begin
			started_q <= 1'b1;
			out_q     <= tx_word_q[5'h17 - fcnt_q]; // R6 R8 R3
		end
	end

	// three flops, one small mux: keeps both clock idle levels
	assign serial_data_out_o = started_q ? out_q : first_q; // R7

	// ---------------- core clock domain ----------------

	// two flops each; the link toggle, scl and sda keep a third for edge detection
	logic [2:0] tgl_sync_q;
	logic [1:0] mode_sync_q;
	logic [1:0] strap1_sync_q;
	logic [1:0] strap0_sync_q;
	logic [2:0] scl_sync_q;
	logic [2:0] sda_sync_q;

	// the mode, strap and bus pins and the link toggle pass two flops first
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tgl_sync_q    <= 3'h0;
			mode_sync_q   <= 2'h0;
			strap1_sync_q <= 2'h0;
			strap0_sync_q <= 2'h0;
			scl_sync_q    <= 3'h7;
			sda_sync_q    <= 3'h7;
		end else begin
			tgl_sync_q    <= {tgl_sync_q[1:0], rx_tgl_q};
			mode_sync_q   <= {mode_sync_q[0], spi_mode_i};
			strap1_sync_q <= {strap1_sync_q[0], address_strap_1_i};
			strap0_sync_q <= {strap0_sync_q[0], address_strap_0_i};
			scl_sync_q    <= {scl_sync_q[1:0], scl_i};
			sda_sync_q    <= {sda_sync_q[1:0], sda_i};
		end
	end

	logic spi_mode;
	logic word_evt;
	assign spi_mode = mode_sync_q[1];
	// rx_word_q is stable for a whole frame after the toggle
	assign word_evt = spi_mode & (tgl_sync_q[2] ^ tgl_sync_q[1]);

	// ---- four-wire word decode ----
	// read bookkeeping: pending answer and echoed address bits
	logic       is_read;
	logic       rd_pend_q;
	logic [9:0] echo_q;
	assign is_read = rx_word_q[dac_port_pkg::RW_POS]; // R1

	// read strobe, then one cycle later the register file answers
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_req_o  <= 1'b0;
			rd_pend_q <= 1'b0;
		end else begin
			rd_req_o  <= word_evt & is_read; // R1
			rd_pend_q <= rd_req_o;
		end
	end

	// a read selects by channel and select bits only
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_sel_o <= '0;
			echo_q   <= 10'h000;
		end else if (word_evt && is_read) begin
			rd_sel_o.chan   <= rx_word_q[21:16]; // R2
			rd_sel_o.regsel <= rx_word_q[15:14]; // R2
			echo_q          <= rx_word_q[23:14]; // R5
		end
	end

	// readback word held still until the next read request
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			tx_word_q <= dac_port_pkg::WORD_RST;
		else if (rd_pend_q)
			tx_word_q <= {echo_q, rd_data_i}; // R5 R3
	end

	// ---- two-wire slave, oversampled ----
	// settled bus levels and the events made from them
	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic start_evt;
	logic stop_evt;
	assign scl_s     = scl_sync_q[1];
	assign sda_s     = sda_sync_q[1];
	assign scl_rise  = scl_s & ~scl_sync_q[2];
	assign scl_fall  = ~scl_s & scl_sync_q[2];
	// data moving while the clock stays high frames the transfer
	assign start_evt = ~spi_mode & scl_s & scl_sync_q[2] &
		sda_sync_q[2] & ~sda_s; // R11
	assign stop_evt  = ~spi_mode & scl_s & scl_sync_q[2] &
		~sda_sync_q[2] & sda_s; // R11

	// transaction state and the byte being received
	dac_port_pkg::phase_e phase_q;
	logic [3:0] bit_q;
	logic [7:0] byte_q;
	logic [7:0] hi_q;
	logic [5:0] chan_q;
	logic       burst_q;
	logic       ack_n_q;
	logic       byte_done;
	logic [7:0] byte_v;
	logic       addr_ok;

	// byte completes at the falling edge after its 8th bit
	assign byte_done = ~spi_mode & scl_fall & (bit_q == dac_port_pkg::BIT_LAST)
		& (phase_q != dac_port_pkg::PH_IDLE);
	assign byte_v    = byte_q;
	assign addr_ok   = byte_v[7:1] == {dac_port_pkg::SLAVE_PREFIX,
		strap1_sync_q[1], strap0_sync_q[1]} && !byte_v[0]; // R10 R13

	// shifter samples data on the rising bus clock only
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			byte_q <= 8'h00;
		else if (!spi_mode && scl_rise &&
			bit_q < dac_port_pkg::BIT_ACK)
			byte_q <= {byte_q[6:0], sda_s};
	end

	// bit counter counts clock falls, 8 marks the ack period
	// a start parks it one below zero: its own fall is no bit
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			bit_q <= 4'h0;
		else if (start_evt)
			bit_q <= 4'hF; // R11
		else if (!spi_mode && scl_fall) begin
			if (bit_q == dac_port_pkg::BIT_ACK)
				bit_q <= 4'h0;
			else
				bit_q <= bit_q + 4'h1;
		end
	end

	// hold data low across the whole ninth clock period
	// kept active low so the pin enable is itself a flop
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			ack_n_q <= 1'b1;
		else if (start_evt || stop_evt)
			ack_n_q <= 1'b1;
		else if (byte_done)
			ack_n_q <= (phase_q == dac_port_pkg::PH_ADDR) &&
				!addr_ok; // R12 R21
		else if (scl_fall && bit_q == dac_port_pkg::BIT_ACK)
			ack_n_q <= 1'b1; // R12
	end

	assign sda_oe_n_o = ack_n_q; // R9

	// drive value registered too; open drain only ever pulls low
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			sda_o <= 1'b0;
		else
			sda_o <= 1'b0;
	end

	// transaction phases: address, pointer, data pair
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			phase_q <= dac_port_pkg::PH_IDLE;
			hi_q    <= 8'h00;
			chan_q  <= dac_port_pkg::CHAN_RST;
			burst_q <= 1'b0;
		end else if (spi_mode) begin
			phase_q <= dac_port_pkg::PH_IDLE; // R9
			burst_q <= 1'b0;
		end else if (start_evt) begin
			phase_q <= dac_port_pkg::PH_ADDR; // R11 R13
			burst_q <= 1'b0;
		end else if (stop_evt) begin
			phase_q <= dac_port_pkg::PH_IDLE; // R18
			burst_q <= 1'b0;
		end else if (byte_done) begin
			case (phase_q)
				dac_port_pkg::PH_ADDR: begin
					// foreign address: sit out until next start
					phase_q <= addr_ok ? dac_port_pkg::PH_PTR
						: dac_port_pkg::PH_IDLE; // R21
				end
				dac_port_pkg::PH_PTR: begin
					phase_q <= dac_port_pkg::PH_DHI; // R14
					if (byte_v == dac_port_pkg::BURST_PTR) begin
						burst_q <= 1'b1; // R16
						chan_q  <= dac_port_pkg::CHAN_RST; // R16
					end else begin
						chan_q  <= byte_v[5:0]; // R14
					end
				end
				dac_port_pkg::PH_DHI: begin
					hi_q    <= byte_v;
					phase_q <= dac_port_pkg::PH_DLO;
				end
				dac_port_pkg::PH_DLO: begin
					if (burst_q) begin
						chan_q  <= chan_q + 6'h01; // R16
						phase_q <= dac_port_pkg::PH_DHI;
					end else begin
						phase_q <= dac_port_pkg::PH_PTR; // R15
					end
				end
				default: phase_q <= dac_port_pkg::PH_IDLE;
			endcase
		end
	end

	// ---- write strobe shared by both interfaces ----
	// a two-wire update completes on the low data byte
	logic two_wire_wr;
	assign two_wire_wr = byte_done & (phase_q == dac_port_pkg::PH_DLO);

	// one strobe per accepted word or completed data pair
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			wr_valid_o <= 1'b0;
		else
			wr_valid_o <= (word_evt & ~is_read) | two_wire_wr; // R14
	end

	// contents hold until the next write replaces them
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_cmd_o <= '0;
		end else begin
			if (word_evt && !is_read) begin
				wr_cmd_o.ab     <= rx_word_q[23]; // R19
				wr_cmd_o.chan   <= rx_word_q[21:16];
				wr_cmd_o.regsel <= rx_word_q[15:14];
				wr_cmd_o.data   <= rx_word_q[13:0];
			end else if (two_wire_wr) begin
				// bank B is never reachable from the two-wire side
				wr_cmd_o.ab     <= 1'b0; // R18
				wr_cmd_o.chan   <= chan_q; // R14 R15
				wr_cmd_o.regsel <= hi_q[7:6]; // R17
				wr_cmd_o.data   <= {hi_q[5:0], byte_v}; // R14
			end
		end
	end

endmodule

// ---- testbench/dhsp_asserts.sv ----
module dhsp_asserts (
	input  wire logic                  sys_clk_i,  // core clock
	input  wire logic                  arst_n_i,   // reset, low
	input  wire logic                  spi_mode_i, // interface select
	input  wire logic                  scl_i,      // bus clock level
	input  wire logic                  sda_o,      // data drive value
	input  wire logic                  sda_oe_n_o, // low: pull data low
	input  wire logic                  wr_valid_o, // write strobe
	input  wire dac_port_pkg::wr_cmd_s wr_cmd_o,   // write contents
	input  wire logic                  rd_req_o,   // read strobe
	input  wire dac_port_pkg::rd_req_s rd_sel_o    // read select
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);

	// open drain: the pin may only ever be pulled low
	a_sda_never_high: assert property (sda_o == 1'b0)
		else $error("data drive value went high");
	// ack begins and ends while the bus clock is low
	a_ack_starts_low: assert property ($fell(sda_oe_n_o) |-> !scl_i)
		else $error("ack started with bus clock high");
	a_ack_ends_low: assert property ($rose(sda_oe_n_o) |-> !scl_i)
		else $error("ack released with bus clock high");
	// ack spans the ninth period, then lets go
	a_ack_whole_period: assert property ($fell(sda_oe_n_o) |=>
		!sda_oe_n_o [*8] ##[1:1000] sda_oe_n_o)
		else $error("ack too short or never released");
	a_write_one_cycle: assert property (wr_valid_o |=> !wr_valid_o)
		else $error("write strobe longer than one cycle");
	a_read_one_cycle: assert property (rd_req_o |=> !rd_req_o)
		else $error("read strobe longer than one cycle");
	a_strobes_apart: assert property (!(wr_valid_o && rd_req_o))
		else $error("read and write strobe together");
	// held outputs only move with their strobe
	a_read_sel_held: assert property (!rd_req_o |-> $stable(rd_sel_o))
		else $error("read select moved without strobe");
	a_write_cmd_held: assert property (!wr_valid_o |-> $stable(wr_cmd_o))
		else $error("write contents moved without strobe");
	a_bus_bank_a: assert property (wr_valid_o && !spi_mode_i &&
		!$past(spi_mode_i, 8) |-> wr_cmd_o.ab == 1'b0)
		else $error("two-wire write not to bank A");
	a_no_ack_fourwire: assert property (spi_mode_i &&
		$past(spi_mode_i, 5) |-> sda_oe_n_o)
		else $error("data pulled low in four-wire mode");
endmodule

// ---- testbench/host_model.sv ----
module host_model (
	output logic      spi_sclk_o, // link clock, idles high
	output logic      sync_n_o,   // frame sync, low
	output logic      din_o,      // link data to device
	input  wire logic sdo_i,      // readback data
	output logic      scl_o,      // bus clock
	output logic      sda_o,      // 1 releases the data line
	input  wire logic sda_i       // data wire level
);
	timeunit 1ns;
	timeprecision 1ps;

	// bus idle, link clock idle high and stopped outside frames
	initial begin
		spi_sclk_o = 1'b1;
		sync_n_o = 1'b1;
		din_o = 1'b0;
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	// n bits msb first at 30 ns, readback sampled on falling edges
	task automatic frame(input logic [23:0] w, input int n,
		output logic [23:0] r);
		sync_n_o = 1'b0;
		din_o = w[23];
		for (int i = 23; i > 23 - n; i--) begin
			#15 spi_sclk_o = 1'b0;
			r[i] = sdo_i;
			#15 spi_sclk_o = 1'b1;
			din_o = (i > 0) ? w[i - 1] : ~w[0];
		end
		#15 sync_n_o = 1'b1;
		din_o = ~din_o; // no stale level after the frame
		#400; // gap lets the readback word settle across domains
	endtask

	// start, also used as repeated start from clock low
	task automatic start();
		sda_o = 1'b1;
		#625 scl_o = 1'b1;
		#625 sda_o = 1'b0;
		#625 scl_o = 1'b0;
	endtask

	// eight bits then a released ninth bit, 400 kHz
	task automatic put_byte(input logic [7:0] b, output logic ack);
		for (int i = 8; i >= 0; i--) begin
			#625 sda_o = (i > 0) ? b[i - 1] : 1'b1;
			#625 scl_o = 1'b1;
			ack = ~sda_i;
			#1250 scl_o = 1'b0;
		end
	endtask

	task automatic stop();
		#625 sda_o = 1'b0;
		#625 scl_o = 1'b1;
		#625 sda_o = 1'b1;
		#625;
	endtask
endmodule

// ---- testbench/dac_host_serial_port_tb.sv ----
`define chk(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
	fails++; $display("wrong value at %0t: got %h expected %h", $time, \
	got, exp); end end

module dac_host_serial_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk_i = 1'b0, arst_n_i = 1'b0, spi_mode_i = 1'b1;
	logic        address_strap_1_i = 1'b0, address_strap_0_i = 1'b0;
	logic        spi_sclk_i, frame_sync_n_i, spi_din_i, serial_data_out_o;
	logic        scl_i, sda_i, sda_h, sda_o, sda_oe_n_o, wr_valid_o, rd_req_o;
	logic [13:0] rd_data_i = 14'h0000;
	logic [31:0] seed = 32'h00000017;
	int          fails = 0, num_checks = 0;
	dac_port_pkg::wr_cmd_s wr_cmd_o, e_w, exp_q[$];
	dac_port_pkg::rd_req_s rd_sel_o, e_r, sel_q[$];

	always #25 sys_clk_i = ~sys_clk_i;
	assign sda_i = sda_h & (sda_oe_n_o | sda_o); // pull-up wire

	dac_host_serial_port i_dac_host_serial_port (.sys_clk_i, .arst_n_i,
		.spi_mode_i, .spi_sclk_i, .frame_sync_n_i, .spi_din_i,
		.serial_data_out_o, .scl_i, .sda_i, .sda_o, .sda_oe_n_o,
		.address_strap_1_i, .address_strap_0_i, .wr_valid_o, .wr_cmd_o,
		.rd_req_o, .rd_sel_o, .rd_data_i);
	host_model i_host_model (.spi_sclk_o(spi_sclk_i), .sync_n_o(frame_sync_n_i),
		.din_o(spi_din_i), .sdo_i(serial_data_out_o), .scl_o(scl_i),
		.sda_o(sda_h), .sda_i(sda_i));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [13:0] reg_val(input dac_port_pkg::rd_req_s s);
		return {s, ~s[5:0]};
	endfunction

	// register file stand-in, answers the cycle after the read strobe
	always @(posedge sys_clk_i)
		if (rd_req_o === 1'b1) rd_data_i <= reg_val(rd_sel_o);

	// strobes sampled mid-cycle against the oldest expectation
	always @(negedge sys_clk_i) begin
		if (wr_valid_o === 1'b1) begin
			`chk(exp_q.size() != 0, 1'b1)
			e_w = exp_q.pop_front();
			`chk(wr_cmd_o, e_w)
		end
		if (rd_req_o === 1'b1) begin
			`chk(sel_q.size() != 0, 1'b1)
			e_r = sel_q.pop_front();
			`chk(rd_sel_o, e_r)
		end
	end

	task automatic spi_wr(input logic [23:0] w);
		logic [23:0] r;
		exp_q.push_back({w[23], w[21:0]});
		i_host_model.frame(w, 24, r);
	endtask
	task automatic i2c_byte(input logic [7:0] b, input logic ack_exp);
		logic a;
		i_host_model.put_byte(b, a);
		`chk(a, ack_exp)
	endtask
	task automatic i2c_upd(input logic [5:0] ch, input logic [15:0] d);
		exp_q.push_back({1'b0, ch, d});
		i2c_byte(d[15:8], 1'b1);
		i2c_byte(d[7:0], 1'b1);
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// watchdog well past the expected two-wire run time
	initial begin
		#3000000;
		fails++;
		end_of_test();
	end

	initial begin
		logic [23:0] w, r;
		logic [1:0]  s;
		logic [6:0]  adr;
		repeat (12) @(posedge sys_clk_i);
		arst_n_i <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		// writes on every select code, a bad frame between them
		for (int k = 0; k < 4; k++) begin
			w = 24'(rnd());
			w[22] = 1'b0;
			w[15:14] = 2'(k);
			spi_wr(w);
			i_host_model.frame(24'(rnd()), 10 + k, r);
		end
		$display("test four-wire write done");
		// read request with junk data bits, then the all-zero word
		for (int k = 0; k < 3; k++) begin
			w = 24'(rnd()) | 24'h400000;
			sel_q.push_back(w[21:14]);
			i_host_model.frame(w, 24, r);
			exp_q.push_back('0);
			i_host_model.frame(24'h000000, 24, r);
			`chk(r, {w[23:14], reg_val(w[21:14])})
		end
		$display("test readback done");
		s = 2'(rnd());
		@(posedge sys_clk_i);
		spi_mode_i <= 1'b0;
		{address_strap_1_i, address_strap_0_i} <= s;
		repeat (10) @(posedge sys_clk_i);
		adr = {dac_port_pkg::SLAVE_PREFIX, s};
		// foreign address, then read direction: both ignored
		i_host_model.start();
		i2c_byte({adr ^ 7'h01, 1'b0}, 1'b0);
		i2c_byte(8'h05, 1'b0);
		i_host_model.start();
		i2c_byte({adr, 1'b1}, 1'b0);
		i_host_model.stop();
		// single update, pointer repeat, then burst after restart
		i_host_model.start();
		i2c_byte({adr, 1'b0}, 1'b1);
		for (int k = 0; k < 2; k++) begin
			i2c_byte(8'h0B + 8'(k * 20), 1'b1);
			i2c_upd(6'h0B + 6'(k * 20), 16'(rnd()));
		end
		i_host_model.start();
		i2c_byte({adr, 1'b0}, 1'b1);
		i2c_byte(dac_port_pkg::BURST_PTR, 1'b1);
		for (int k = 0; k < 4; k++)
			i2c_upd(6'(k), {2'(k), 14'(rnd())});
		i_host_model.stop();
		// after a stop the next byte is a pointer again
		i_host_model.start();
		i2c_byte({adr, 1'b0}, 1'b1);
		i2c_byte(8'h05, 1'b1);
		i2c_upd(6'h05, 16'(rnd()));
		i_host_model.stop();
		$display("test two-wire done");
		`chk(exp_q.size() + sel_q.size(), 0)
		end_of_test();
	end
endmodule

bind dac_host_serial_port dhsp_asserts i_dhsp_asserts (.sys_clk_i, .arst_n_i,
	.spi_mode_i, .scl_i, .sda_o, .sda_oe_n_o, .wr_valid_o, .wr_cmd_o,
	.rd_req_o, .rd_sel_o);
